// ===== core/lin_slave_frame_handler.sv
// Behaviour
// - frame is master header, then one response
// - respond only to identifiers assigned here
// - byte: start, 8 data lsb first, stop
// - up to 61 response ids, 00h-3bh, 3dh
// - id 3ch: receive 8 bytes, 00h sets sleep
// - id 3dh assigned: send eight byte response
// - ids 3eh, 3fh: ignore, wait for break
// - response length from identifier length bits
// - clock/8 timer measures break, sync, timeouts
// - in standby, falling bus edge means wake
// - receiver reports byte errors to frame logic
// - wake signal sent through byte transmitter
// - divisor and timings derived from clock, rate
`timescale 1ns/1ps
`include "lin_defines.svh"

module lin_slave_frame_handler #(
    parameter int CLK_HZ     = `LIN_CLK_HZ,
    parameter int BAUD       = `LIN_BAUD,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          bus_rx,
    output logic               bus_tx,
    input  wire logic [63:0]   resp_id_en,
    input  wire logic          resp_valid,
    input  wire logic [7:0]    resp_data,
    output logic               resp_ready,
    output lin_pkg::byte_strm_t rx_data,
    output lin_pkg::hdr_evt_t  hdr,
    output logic               frame_done,
    output lin_pkg::err_evt_t  err,
    output logic               sleep_flag,
    input  wire logic          sleep_clr,
    input  wire logic          standby,
    output logic               wake_detect,
    input  wire logic          wake_req,
    output logic [15:0]        sync_ticks
);
    import lin_pkg::*;

    // ----------------------------------------------------------------
    // derived timing
    // ----------------------------------------------------------------
    localparam int DIV       = CLK_HZ / BAUD;
    localparam int TPB       = CLK_HZ / (`LIN_TIMER_PRESCALE * BAUD);
    localparam int BRK_TICKS = `LIN_BREAK_BITS * TPB;
    localparam int TMO_TICKS = `LIN_TIMEOUT_BITS * TPB;
    localparam logic [15:0] DIV_W = 16'(DIV);
    localparam logic [15:0] BRK_W = 16'(BRK_TICKS);
    localparam logic [15:0] TMO_W = 16'(TMO_TICKS);
    localparam logic [63:0] RESP_MASK = `LIN_RESP_ID_MASK;

    frm_regs_t q;
    frm_regs_t d;
    rx_evt_t   rx;
    logic      tx_busy;
    logic      fifo_valid;
    logic [7:0] fifo_data;
    logic      tick;
    logic      timed;

    function automatic logic parity_ok(input logic [7:0] f);
        logic p0;
        logic p1;
        p0 = f[0] ^ f[1] ^ f[2] ^ f[4];
        p1 = ~(f[1] ^ f[3] ^ f[4] ^ f[5]);
        return (f[6] == p0) && (f[7] == p1);
    endfunction

    function automatic logic [3:0] dlc_len(input logic [5:0] id);
        logic [3:0] n;
        case (id[5:4])
            2'b10:   n = `LIN_LEN_4;
            2'b11:   n = `LIN_LEN_8;
            default: n = `LIN_LEN_2;
        endcase
        return n;
    endfunction

    function automatic logic [7:0] csum_add(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[7:0] + {7'b0, s[8]};
    endfunction

    // ----------------------------------------------------------------
    // byte serial unit and response buffer
    // ----------------------------------------------------------------
    async_byte_serial_unit u_ser (
        .mclk             (mclk),
        .rst              (rst),
        .bit_rate_divisor (DIV_W),
        .rx_in            (q.sy[1]),
        .tx_req           (q.tx_req),
        .tx_byte          (q.tx_byte),
        .tx_busy          (tx_busy),
        .tx_out           (bus_tx),
        .rx_evt           (rx)
    );

    resp_fifo #(
        .W     (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (resp_valid),
        .in_data   (resp_data),
        .in_ready  (resp_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (q.pop)
    );

    assign rx_data     = q.rx_out;
    assign hdr         = q.hdr;
    assign frame_done  = q.done;
    assign err         = q.err;
    assign sleep_flag  = q.sleep;
    assign wake_detect = q.wake_det;
    assign sync_ticks  = q.sync_ticks;

    // ----------------------------------------------------------------
    // frame sequencer
    // ----------------------------------------------------------------
    always_comb begin
        d              = q;
        d.sy           = {q.sy[1], q.sy[0], bus_rx};
        d.rx_out.valid = 1'b0;
        d.hdr.valid    = 1'b0;
        d.done         = 1'b0;
        d.err          = '0;
        d.wake_det     = 1'b0;
        d.tx_req       = 1'b0;
        d.pop          = 1'b0;

        tick  = (q.pre == 3'(`LIN_TIMER_PRESCALE - 1));
        d.pre = tick ? 3'd0 : q.pre + 3'd1;
        if (tick && (q.ticks != 16'hffff)) begin
            d.ticks = q.ticks + 16'd1;
        end

        if (standby && q.sy[2] && !q.sy[1]) begin
            d.wake_det = 1'b1;
        end
        if (sleep_clr) begin
            d.sleep = 1'b0;
        end

        timed = (q.st == ST_SYNC) || (q.st == ST_ID) || (q.st == ST_RX)
             || (q.st == ST_TX) || (q.st == ST_TX_END);

        if (timed && (q.ticks >= TMO_W)) begin
            d.err.timeout = 1'b1;
            d.st          = ST_IDLE;
        end else begin
            case (q.st)
                ST_IDLE: begin
                    d.ticks = '0;
                    if (wake_req && !tx_busy) begin
                        d.tx_req  = 1'b1;
                        d.tx_byte = `LIN_WAKE_BYTE;
                        d.st      = ST_WAKE;
                    end else if (!q.sy[1]) begin
                        d.st = ST_BRK;
                    end
                end
                ST_WAKE: begin
                    if (!q.tx_req && !tx_busy) begin
                        d.st = ST_IDLE;
                    end
                end
                ST_BRK: begin
                    if (q.sy[1]) begin
                        d.ticks = '0;
                        d.st    = (q.ticks >= BRK_W) ? ST_SYNC : ST_IDLE;
                    end
                end
                ST_SYNC: begin
                    if (rx.valid) begin
                        d.ticks = '0;
                        if (rx.ferr || (rx.data != `LIN_SYNC_BYTE)) begin
                            d.err.rx_err = 1'b1;
                            d.st         = ST_IDLE;
                        end else begin
                            d.sync_ticks = q.ticks;
                            d.st         = ST_ID;
                        end
                    end
                end
                ST_ID: begin
                    if (rx.valid) begin
                        d.ticks = '0;
                        d.idx   = '0;
                        d.csum  = '0;
                        d.id    = rx.data[5:0];
                        d.len   = dlc_len(rx.data[5:0]);
                        if (rx.ferr) begin
                            d.err.rx_err = 1'b1;
                            d.st         = ST_IDLE;
                        end else if (!parity_ok(rx.data)) begin
                            d.err.parity_err = 1'b1;
                            d.st             = ST_IDLE;
                        end else begin
                            d.hdr = '{valid: 1'b1, id: rx.data[5:0]};
                            if ((rx.data[5:0] == `LIN_ID_EXT0)
                                || (rx.data[5:0] == `LIN_ID_EXT1)) begin
                                d.st = ST_IDLE;
                            end else if (rx.data[5:0] == `LIN_ID_MASTER_REQ) begin
                                d.len = `LIN_LEN_8;
                                d.st  = ST_RX;
                            end else if (resp_id_en[rx.data[5:0]]
                                && RESP_MASK[rx.data[5:0]]) begin
                                d.st = ST_TX;
                            end else begin
                                d.st = ST_IDLE;
                            end
                        end
                    end
                end
                ST_RX: begin
                    if (rx.valid) begin
                        d.ticks = '0;
                        if (rx.ferr) begin
                            d.err.rx_err = 1'b1;
                            d.st         = ST_IDLE;
                        end else if (q.idx != q.len) begin
                            d.rx_out = '{valid: 1'b1, data: rx.data};
                            d.csum   = csum_add(q.csum, rx.data);
                            d.idx    = q.idx + 4'd1;
                            if ((q.idx == 4'd0) && (rx.data == `LIN_SLEEP_CMD)) begin
                                d.sleep = 1'b1;
                            end
                        end else begin
                            d.err.csum_err = (rx.data != ~q.csum);
                            d.done         = 1'b1;
                            d.st           = ST_IDLE;
                        end
                    end
                end
                ST_TX: begin
                    if (!q.tx_req && !tx_busy) begin
                        if (q.idx != q.len) begin
                            if (fifo_valid) begin
                                d.pop     = 1'b1;
                                d.tx_req  = 1'b1;
                                d.tx_byte = fifo_data;
                                d.csum    = csum_add(q.csum, fifo_data);
                                d.idx     = q.idx + 4'd1;
                                d.ticks   = '0;
                            end
                        end else begin
                            d.tx_req  = 1'b1;
                            d.tx_byte = ~q.csum;
                            d.ticks   = '0;
                            d.st      = ST_TX_END;
                        end
                    end
                end
                ST_TX_END: begin
                    if (!q.tx_req && !tx_busy) begin
                        d.done = 1'b1;
                        d.st   = ST_IDLE;
                    end
                end
                default: begin
                    d.st = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            q    <= '0;
            q.sy <= 3'b111;
        end else begin
            q <= d;
        end
    end

endmodule

// ===== inc/lin_defines.svh
`ifndef LIN_DEFINES_SVH
`define LIN_DEFINES_SVH

// ----------------------------------------------------------------
// clock and transfer rate
// ----------------------------------------------------------------
`define LIN_CLK_HZ          125000000
`define LIN_CLK_PERIOD_NS   8
`define LIN_BAUD            19200
`define LIN_TIMER_PRESCALE  8

// ----------------------------------------------------------------
// timing counts, in bit times
// ----------------------------------------------------------------
`define LIN_BREAK_BITS      11
`define LIN_TIMEOUT_BITS    20

// ----------------------------------------------------------------
// byte framing
// ----------------------------------------------------------------
`define LIN_STOP_BIT_IDX    4'd9

// ----------------------------------------------------------------
// identifiers and field values
// ----------------------------------------------------------------
`define LIN_ID_MASTER_REQ   6'h3c
`define LIN_ID_SLAVE_RESP   6'h3d
`define LIN_ID_EXT0         6'h3e
`define LIN_ID_EXT1         6'h3f
`define LIN_RESP_ID_MASK    64'h2fff_ffff_ffff_ffff
`define LIN_SYNC_BYTE       8'h55
`define LIN_SLEEP_CMD       8'h00
`define LIN_WAKE_BYTE       8'h80
`define LIN_LEN_2           4'h2
`define LIN_LEN_4           4'h4
`define LIN_LEN_8           4'h8

`endif

// ===== inc/lin_pkg.sv
package lin_pkg;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } byte_strm_t;

    typedef struct packed {
        logic       valid;
        logic       ferr;
        logic [7:0] data;
    } rx_evt_t;

    typedef struct packed {
        logic       valid;
        logic [5:0] id;
    } hdr_evt_t;

    typedef struct packed {
        logic timeout;
        logic rx_err;
        logic parity_err;
        logic csum_err;
    } err_evt_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_BRK, ST_SYNC, ST_ID, ST_RX, ST_TX, ST_TX_END, ST_WAKE
    } frm_state_t;

    typedef struct packed {
        logic        rx_armed;
        logic        rx_busy;
        logic [15:0] rx_cnt;
        logic [3:0]  rx_bit;
        logic [7:0]  rx_sh;
        rx_evt_t     evt;
        logic        tx_busy;
        logic [15:0] tx_cnt;
        logic [3:0]  tx_bit;
        logic [9:0]  tx_sh;
        logic        tx_out;
    } ser_regs_t;

    typedef struct packed {
        frm_state_t  st;
        logic [2:0]  pre;
        logic [15:0] ticks;
        logic [2:0]  sy;
        logic [5:0]  id;
        logic [3:0]  len;
        logic [3:0]  idx;
        logic [7:0]  csum;
        logic        tx_req;
        logic [7:0]  tx_byte;
        logic        pop;
        byte_strm_t  rx_out;
        hdr_evt_t    hdr;
        logic        done;
        err_evt_t    err;
        logic        sleep;
        logic        wake_det;
        logic [15:0] sync_ticks;
    } frm_regs_t;

endpackage

// ===== core/resp_fifo.sv
`timescale 1ns/1ps

module resp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr;
        logic [AW-1:0]           rd;
        logic [AW:0]             cnt;
        logic                    ready;
    } fifo_regs_t;

    fifo_regs_t q;
    fifo_regs_t d;
    logic       push;
    logic       pull;

    assign in_ready  = q.ready;
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rd];

    always_comb begin
        d    = q;
        push = in_valid && q.ready;
        pull = out_ready && (q.cnt != '0);
        if (push) begin
            d.mem[q.wr] = in_data;
            d.wr        = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + AW'(1);
        end
        if (pull) begin
            d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + AW'(1);
        end
        d.cnt   = q.cnt + (AW+1)'(push) - (AW+1)'(pull);
        d.ready = (d.cnt < (AW+1)'(DEPTH));
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            q       <= '0;
            q.ready <= 1'b1;
        end else begin
            q <= d;
        end
    end

endmodule

// ===== core/async_byte_serial_unit.sv
`timescale 1ns/1ps
`include "lin_defines.svh"

module async_byte_serial_unit (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [15:0] bit_rate_divisor,
    input  wire logic        rx_in,
    input  wire logic        tx_req,
    input  wire logic [7:0]  tx_byte,
    output logic             tx_busy,
    output logic             tx_out,
    output lin_pkg::rx_evt_t rx_evt
);
    import lin_pkg::*;

    ser_regs_t q;
    ser_regs_t d;

    assign tx_busy = q.tx_busy;
    assign tx_out  = q.tx_out;
    assign rx_evt  = q.evt;

    always_comb begin
        d           = q;
        d.evt.valid = 1'b0;
        // ----------------------------------------------------------------
        // receiver: start, 8 data lsb first, stop sampled mid-bit
        // ----------------------------------------------------------------
        if (!q.rx_busy) begin
            if (rx_in) begin
                d.rx_armed = 1'b1;
            end else if (q.rx_armed) begin
                d.rx_busy  = 1'b1;
                d.rx_armed = 1'b0;
                d.rx_cnt   = {1'b0, bit_rate_divisor[15:1]};
                d.rx_bit   = '0;
            end
        end else if (q.rx_cnt != '0) begin
            d.rx_cnt = q.rx_cnt - 16'd1;
        end else begin
            d.rx_cnt = bit_rate_divisor - 16'd1;
            d.rx_bit = q.rx_bit + 4'd1;
            if (q.rx_bit == 4'd0) begin
                if (rx_in) begin
                    d.rx_busy = 1'b0;
                end
            end else if (q.rx_bit != `LIN_STOP_BIT_IDX) begin
                d.rx_sh = {rx_in, q.rx_sh[7:1]};
            end else begin
                d.rx_busy  = 1'b0;
                d.rx_armed = rx_in;
                d.evt      = '{valid: 1'b1, ferr: !rx_in, data: q.rx_sh};
            end
        end
        // ----------------------------------------------------------------
        // transmitter
        // ----------------------------------------------------------------
        if (!q.tx_busy) begin
            if (tx_req) begin
                d.tx_busy = 1'b1;
                d.tx_sh   = {1'b1, tx_byte, 1'b0};
                d.tx_cnt  = bit_rate_divisor - 16'd1;
                d.tx_bit  = '0;
                d.tx_out  = 1'b0;
            end
        end else if (q.tx_cnt != '0) begin
            d.tx_cnt = q.tx_cnt - 16'd1;
        end else if (q.tx_bit == `LIN_STOP_BIT_IDX) begin
            d.tx_busy = 1'b0;
            d.tx_out  = 1'b1;
        end else begin
            d.tx_sh  = {1'b1, q.tx_sh[9:1]};
            d.tx_out = q.tx_sh[1];
            d.tx_bit = q.tx_bit + 4'd1;
            d.tx_cnt = bit_rate_divisor - 16'd1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            q        <= '0;
            q.tx_out <= 1'b1;
        end else begin
            q <= d;
        end
    end

endmodule

// ===== verif/lin_master_model.sv
`timescale 1ns/1ps

module lin_master_model #(
    parameter int DIV = 80
) (
    input  wire logic mclk,
    input  wire logic line,
    output logic      mtx
);
    // ----------------------------------------------------------------
    // master side of the wire; bytes the slave sends are decoded
    // ----------------------------------------------------------------
    logic [8:0] rq[$];
    logic [8:0] b;

    initial mtx = 1'b1;

    task automatic hold(int n, logic v);
        mtx = v;
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic send_byte(logic [7:0] d);
        hold(DIV, 1'b0);
        for (int i = 0; i < 8; i++) hold(DIV, d[i]);
        hold(DIV, 1'b1);
    endtask

    task automatic send_hdr(logic [7:0] s, logic [7:0] f);
        hold(13 * DIV, 1'b0);
        hold(DIV, 1'b1);
        send_byte(s);
        send_byte(f);
    endtask

    // own bytes are skipped: only edges while the master is recessive
    always begin
        @(negedge line);
        if (mtx) begin
            repeat (DIV / 2) @(posedge mclk);
            for (int i = 0; i < 9; i++) begin
                repeat (DIV) @(posedge mclk);
                b = {line, b[8:1]};
            end
            rq.push_back(b);
        end
    end
endmodule

// ===== verif/lin_slave_frame_handler_asserts.sv
`timescale 1ns/1ps

module lin_slave_frame_handler_asserts #(
    parameter int CLK_HZ = 1600000,
    parameter int BAUD   = 20000
) (
    input wire logic                mclk,
    input wire logic                rst,
    input wire logic                bus_tx,
    input wire logic [63:0]         resp_id_en,
    input wire logic                resp_valid,
    input wire logic                resp_ready,
    input wire lin_pkg::byte_strm_t rx_data,
    input wire lin_pkg::hdr_evt_t   hdr,
    input wire logic                frame_done,
    input wire lin_pkg::err_evt_t   err,
    input wire logic                sleep_flag,
    input wire logic                sleep_clr,
    input wire logic                standby,
    input wire logic                wake_detect
);
    import lin_pkg::*;
    localparam int DIV = CLK_HZ / BAUD;
    logic [15:0] low_q;

    always_ff @(posedge mclk) begin
        if (rst || bus_tx) begin
            low_q <= '0;
        end else begin
            low_q <= low_q + 16'h0001;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_start_bit;
        !bus_tx[*8];
    endsequence
    sequence s_quiet;
        bus_tx[*8];
    endsequence
    sequence s_foreign_hdr;
        hdr.valid && !(resp_id_en[hdr.id] && hdr.id != 6'h3c && hdr.id < 6'h3e);
    endsequence

    AST_RESET_VALUES: assert property ($fell(rst) |-> bus_tx && resp_ready && !sleep_flag)
        else $error("outputs not at reset values");
    AST_HDR_PULSE: assert property (hdr.valid |=> !hdr.valid)
        else $error("header pulse too long");
    AST_IGNORE_QUIET: assert property (s_foreign_hdr |=> s_quiet)
        else $error("bus driven for a foreign id");
    AST_START_BIT: assert property ($fell(bus_tx) |-> s_start_bit)
        else $error("start bit too short");
    AST_STOP_BIT: assert property (low_q <= 16'(9 * DIV + 1))
        else $error("no stop bit after nine bit times");
    AST_SLEEP_HOLD: assert property (sleep_flag && !sleep_clr |=> sleep_flag)
        else $error("sleep flag lost");
    AST_WAKE_STANDBY: assert property (wake_detect |-> $past(standby))
        else $error("wake outside standby");
    AST_FIFO_FULL: assert property ($fell(resp_ready) |-> $past(resp_valid))
        else $error("fifo full without a push");
    AST_ERR_PULSE: assert property (|err |=> !(|err))
        else $error("error pulse too long");
    AST_DONE_IDLE: assert property (frame_done |-> bus_tx && !rx_data.valid)
        else $error("frame done while bus busy");
endmodule

bind lin_slave_frame_handler lin_slave_frame_handler_asserts #(.CLK_HZ(CLK_HZ), .BAUD(BAUD))
    u_lin_slave_frame_handler_asserts (.mclk, .rst, .bus_tx, .resp_id_en, .resp_valid,
    .resp_ready, .rx_data, .hdr, .frame_done, .err, .sleep_flag, .sleep_clr, .standby,
    .wake_detect);

// ===== verif/lin_slave_frame_handler_tb_top.sv
`timescale 1ns/1ps

module lin_slave_frame_handler_tb_top;
    import lin_pkg::*;
    localparam int DIV = 80;
    logic        mclk = 0, rst = 1, sleep_clr = 0, standby = 0, wake_req = 0;
    logic        resp_valid = 0, mtx, line, bus_tx, resp_ready;
    logic        frame_done, sleep_flag, wake_detect;
    logic [7:0]  resp_data = 0;
    logic [63:0] resp_id_en = 64'h2000_0000_0000_0004;
    logic [15:0] sync_ticks;
    logic [5:0]  m_id;
    byte_strm_t  rx_data;
    hdr_evt_t    hdr;
    err_evt_t    err, m_err;
    int          num_errors = 0, n_tests = 0, m_done, m_wake, m_low;
    logic [7:0]  rxq[$];

    // pulled-up wire, either side may pull it low
    assign line = mtx & bus_tx;
    always #4 mclk = ~mclk;

    lin_slave_frame_handler #(.CLK_HZ(1600000), .BAUD(20000)) u_lin_slave_frame_handler (
        .mclk, .rst, .bus_rx(line), .bus_tx, .resp_id_en, .resp_valid, .resp_data,
        .resp_ready, .rx_data, .hdr, .frame_done, .err, .sleep_flag, .sleep_clr,
        .standby, .wake_detect, .wake_req, .sync_ticks);
    lin_master_model #(.DIV(DIV)) u_lin_master_model (.mclk, .line, .mtx);

    // ----------------------------------------------------------------
    // pulse collector
    // ----------------------------------------------------------------
    always @(posedge mclk) begin
        if (hdr.valid) m_id = hdr.id;
        if (rx_data.valid) rxq.push_back(rx_data.data);
        m_done += int'(frame_done);
        m_wake += int'(wake_detect);
        m_low += int'(!bus_tx);
        m_err = m_err | err;
    end

    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic clr;
        m_done = 0;
        m_wake = 0;
        m_low = 0;
        m_err = '0;
        m_id = '0;
        rxq.delete();
        u_lin_master_model.rq.delete();
    endtask

    function automatic logic [7:0] csum(logic [7:0] d[8]);
        logic [8:0] s;
        s = '0;
        foreach (d[i]) begin
            s = s + {1'b0, d[i]};
            if (s[8]) s = s - 9'd255;
        end
        return ~s[7:0];
    endfunction

    task automatic rx_chk(string w, logic [7:0] e);
        int n;
        for (n = 0; n < 40 * DIV && u_lin_master_model.rq.size() == 0; n++) tick(1);
        chk(w, {7'h0, n < 40 * DIV ? u_lin_master_model.rq.pop_front() : 9'h0}, {8'h01, e});
        if (n == 40 * DIV) test_done;
    endtask

    task automatic t_master_req;
        logic [7:0] d[8];
        clr;
        u_lin_master_model.send_hdr(8'h55, 8'h3c);
        foreach (d[i]) d[i] = 8'(i * 19);
        foreach (d[i]) u_lin_master_model.send_byte(d[i]);
        u_lin_master_model.send_byte(csum(d));
        tick(2 * DIV);
        chk("hdr_id", 16'(m_id), 16'h003c);
        chk("rx_count", 16'(rxq.size()), 16'd8);
        foreach (d[i]) chk("rx_byte", 16'(rxq[i]), 16'(d[i]));
        chk("rx_done", 16'(m_done), 16'd1);
        chk("tx_quiet", 16'(m_low), 16'd0);
        chk("sleep_set", 16'(sleep_flag), 16'd1);
        chk("sync_ticks", 16'(sync_ticks inside {[16'd100:16'd112]}), 16'd1);
        sleep_clr = 1;
        tick(1);
        sleep_clr = 0;
        tick(1);
        chk("sleep_clr", 16'(sleep_flag), 16'd0);
    endtask

    task automatic t_resp;
        logic [7:0] d[8];
        clr;
        foreach (d[i]) d[i] = 8'(8'h5a + i * 37);
        resp_valid = 1;
        foreach (d[i]) begin
            resp_data = d[i];
            tick(1);
        end
        resp_valid = 0;
        chk("fifo_full", 16'(resp_ready), 16'd0);
        u_lin_master_model.send_hdr(8'h55, 8'h7d);
        foreach (d[i]) rx_chk("resp_byte", d[i]);
        rx_chk("resp_csum", csum(d));
        tick(DIV);
        chk("resp_done", 16'(m_done), 16'd1);
        chk("fifo_empty", 16'(resp_ready), 16'd1);
        clr;
        foreach (d[i]) if (i > 1) d[i] = '0;
        resp_valid = 1;
        for (int i = 0; i < 2; i++) begin
            resp_data = d[i];
            tick(1);
        end
        resp_valid = 0;
        u_lin_master_model.send_hdr(8'h55, 8'h42);
        rx_chk("len2_b0", d[0]);
        rx_chk("len2_b1", d[1]);
        rx_chk("len2_csum", csum(d));
        tick(DIV);
        chk("len2_done", 16'(m_done), 16'd1);
    endtask

    task automatic t_ignore;
        logic [7:0] f[3] = '{8'h85, 8'hfe, 8'hbf};
        foreach (f[i]) begin
            clr;
            u_lin_master_model.send_hdr(8'h55, f[i]);
            tick(25 * DIV);
            chk("ignore_low", 16'(m_low), 16'd0);
            chk("ignore_err", 16'(m_err), 16'd0);
        end
    endtask

    task automatic t_err;
        logic [7:0] s[3] = '{8'h54, 8'h55, 8'h55};
        logic [7:0] f[3] = '{8'h3c, 8'hbc, 8'h3c};
        logic [3:0] e[3] = '{4'h4, 4'h2, 4'h8};
        foreach (s[i]) begin
            clr;
            u_lin_master_model.send_hdr(s[i], f[i]);
            tick(25 * DIV);
            chk("err_kind", 16'(m_err), 16'(e[i]));
        end
        clr;
        u_lin_master_model.send_hdr(8'h55, 8'h3c);
        repeat (9) u_lin_master_model.send_byte(8'h01);
        tick(DIV);
        chk("csum_err", 16'(m_err), 16'h0001);
    endtask

    task automatic t_wake;
        standby = 1;
        tick(4);
        clr;
        u_lin_master_model.hold(DIV, 1'b0);
        u_lin_master_model.hold(DIV, 1'b1);
        standby = 0;
        chk("wake_seen", 16'(m_wake), 16'd1);
        clr;
        wake_req = 1;
        tick(1);
        wake_req = 0;
        rx_chk("wake_byte", 8'h80);
        chk("wake_quiet", 16'(m_wake), 16'd0);
    endtask

    initial begin
        tick(3);
        rst = 0;
        tick(4);
        chk("reset_tx", 16'(bus_tx), 16'd1);
        chk("reset_ready", 16'(resp_ready), 16'd1);
        chk("reset_sync", sync_ticks, 16'd0);
        t_master_req;
        t_err;
        t_resp;
        t_ignore;
        t_wake;
        test_done;
    end
endmodule
